// ### logic/sleep_clock_gating.sv
// Implementation choice: the AHB-Lite slave port.
module sleep_clock_gating (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sleeping,
  input wire logic unit_access,
  input wire logic [31:0] unit_select,
  output logic unit_fault,
  output logic [31:0] unit_clock_en,
  output logic comparator_clock_gate,
  output logic gp_timer_a_clock_gate,
  output logic gp_timer_b_clock_gate,
  output logic gp_timer_c_clock_gate,
  output logic gp_timer_d_clock_gate,
  output logic twowire_clock_gate,
  output logic quad_encoder_clock_gate,
  output logic sync_serial_clock_gate,
  output logic async_serial_a_clock_gate,
  output logic async_serial_b_clock_gate,
  output logic async_serial_c_clock_gate,
  output logic irq
);
  logic [31:0] sleep_clock_gate_reg_q;
  logic [31:0] run_clock_gate_reg_q;
  logic [31:0] run_clock_config_reg_q;
  logic [31:0] irq_status_q;
  logic [31:0] irq_mask_q;
  logic [31:0] en_q;
  logic [31:0] en_d;
  logic wr_pend_q;
  logic [11:0] wr_addr_q;
  logic [31:0] rdata_d;
  logic fault_q;
  logic [31:0] status_d;
  logic [31:0] sleep_clock_gate_reg_d;
  logic [31:0] run_clock_gate_reg_d;
  logic [31:0] run_clock_config_reg_d;
  logic [31:0] irq_mask_d;

  function automatic logic [31:0] fld(input logic [31:0] v, input logic [31:0] m);
    fld = v & m;
  endfunction

  wire addr_phase = hsel && hready && htrans[1] && (hsize == 3'h2);
  wire [11:0] a_off = haddr[11:0];
  wire auto_clock_gating = run_clock_config_reg_q[sleep_gate_pkg::auto_gating_bit];
  wire use_sleep = sleeping && auto_clock_gating;
  wire [31:0] en_sel = use_sleep ? sleep_clock_gate_reg_q : run_clock_gate_reg_q;
  wire switching = (en_d != en_q);
  wire fault_now = unit_access && ((unit_select & en_q) == 32'h00000000);
  wire wr_sleep = wr_pend_q && (wr_addr_q == sleep_gate_pkg::sleep_gate_off);
  wire wr_run = wr_pend_q && (wr_addr_q == sleep_gate_pkg::run_gate_off);
  wire wr_ctrl = wr_pend_q && (wr_addr_q == sleep_gate_pkg::ctrl_off);
  wire wr_stat = wr_pend_q && (wr_addr_q == sleep_gate_pkg::irq_status_off);
  wire wr_mask = wr_pend_q && (wr_addr_q == sleep_gate_pkg::irq_mask_off);

  assign en_d = fld(en_sel, sleep_gate_pkg::gate_mask);

  assign sleep_clock_gate_reg_d = wr_sleep ? fld(hwdata, sleep_gate_pkg::gate_mask)
    : sleep_clock_gate_reg_q;
  assign run_clock_gate_reg_d = wr_run ? fld(hwdata, sleep_gate_pkg::gate_mask)
    : run_clock_gate_reg_q;
  assign run_clock_config_reg_d = wr_ctrl ? fld(hwdata, sleep_gate_pkg::ctrl_mask)
    : run_clock_config_reg_q;
  assign irq_mask_d = wr_mask ? fld(hwdata, sleep_gate_pkg::irq_mask_bits)
    : irq_mask_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign unit_clock_en = en_q;
  assign unit_fault = fault_q;
  assign comparator_clock_gate = en_q[sleep_gate_pkg::comparator_bit];
  assign gp_timer_a_clock_gate = en_q[sleep_gate_pkg::gp_timer_a_bit];
  assign gp_timer_b_clock_gate = en_q[sleep_gate_pkg::gp_timer_a_bit + 1];
  assign gp_timer_c_clock_gate = en_q[sleep_gate_pkg::gp_timer_a_bit + 2];
  assign gp_timer_d_clock_gate = en_q[sleep_gate_pkg::gp_timer_d_bit];
  assign twowire_clock_gate = en_q[sleep_gate_pkg::twowire_bit];
  assign quad_encoder_clock_gate = en_q[sleep_gate_pkg::quad_encoder_bit];
  assign sync_serial_clock_gate = en_q[sleep_gate_pkg::sync_serial_bit];
  assign async_serial_a_clock_gate = en_q[sleep_gate_pkg::async_serial_a_bit];
  assign async_serial_b_clock_gate = en_q[sleep_gate_pkg::async_serial_a_bit + 1];
  assign async_serial_c_clock_gate = en_q[sleep_gate_pkg::async_serial_c_bit];
  assign irq = |(irq_status_q & irq_mask_q);

  always_comb
  begin
    unique case (a_off)
      sleep_gate_pkg::sleep_gate_off: rdata_d = sleep_clock_gate_reg_d;
      sleep_gate_pkg::run_gate_off: rdata_d = run_clock_gate_reg_d;
      sleep_gate_pkg::ctrl_off: rdata_d = run_clock_config_reg_d;
      sleep_gate_pkg::irq_status_off: rdata_d = status_d;
      sleep_gate_pkg::irq_mask_off: rdata_d = irq_mask_d;
      default: rdata_d = 32'h00000000;
    endcase
  end

  // sticky events, set wins over write-one-to-clear
  always_comb
  begin
    status_d = irq_status_q;
    if (wr_stat)
    begin
      status_d = status_d & ~fld(hwdata, sleep_gate_pkg::irq_mask_bits);
    end
    if (fault_now)
    begin
      status_d[sleep_gate_pkg::irq_fault_bit] = 1'b1;
    end
    if (switching)
    begin
      status_d[sleep_gate_pkg::irq_switch_bit] = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      hrdata <= 32'h00000000;
    end
    else
    begin
      wr_pend_q <= addr_phase && hwrite;
      wr_addr_q <= a_off;
      if (addr_phase && !hwrite)
      begin
        hrdata <= rdata_d;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      sleep_clock_gate_reg_q <= sleep_gate_pkg::gate_reset;
      run_clock_gate_reg_q <= sleep_gate_pkg::gate_reset;
      run_clock_config_reg_q <= 32'h00000000;
      irq_mask_q <= 32'h00000000;
    end
    else
    begin
      sleep_clock_gate_reg_q <= sleep_clock_gate_reg_d;
      run_clock_gate_reg_q <= run_clock_gate_reg_d;
      run_clock_config_reg_q <= run_clock_config_reg_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  // enables leave a flip-flop so gate latches see clean levels
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      en_q <= sleep_gate_pkg::gate_reset;
      fault_q <= 1'b0;
      irq_status_q <= 32'h00000000;
    end
    else
    begin
      en_q <= en_d;
      fault_q <= fault_now;
      irq_status_q <= status_d;
    end
  end

  a_sleep_select: assert property (@(posedge clk) disable iff (!rst_b)
    (sleeping && auto_clock_gating) |=> (en_q == fld($past(sleep_clock_gate_reg_q),
      sleep_gate_pkg::gate_mask)))
    else $error("sleep enables not applied");
  a_run_select: assert property (@(posedge clk) disable iff (!rst_b)
    !(sleeping && auto_clock_gating) |=> (en_q == $past(run_clock_gate_reg_q)))
    else $error("run enables not applied");
  a_fault_gated: assert property (@(posedge clk) disable iff (!rst_b)
    (unit_access && ((unit_select & en_q) == 32'h00000000)) |=> unit_fault)
    else $error("missing fault");
  a_no_fault_open: assert property (@(posedge clk) disable iff (!rst_b)
    (unit_access && ((unit_select & en_q) != 32'h00000000)) |=> !unit_fault)
    else $error("spurious fault");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_b)
    (sleep_clock_gate_reg_q & ~sleep_gate_pkg::gate_mask) == 32'h00000000)
    else $error("reserved bit set");
  sequence s_sleep_write;
    wr_pend_q && (wr_addr_q == sleep_gate_pkg::sleep_gate_off);
  endsequence
  a_gate_write: assert property (@(posedge clk) disable iff (!rst_b)
    s_sleep_write |=> (sleep_clock_gate_reg_q == fld($past(hwdata), sleep_gate_pkg::gate_mask)))
    else $error("gate write lost");
  a_comp_map: assert property (@(posedge clk) disable iff (!rst_b)
    comparator_clock_gate == unit_clock_en[24])
    else $error("comparator map wrong");
  a_timer_map: assert property (@(posedge clk) disable iff (!rst_b)
    {gp_timer_d_clock_gate, gp_timer_a_clock_gate} == {unit_clock_en[19], unit_clock_en[16]})
    else $error("timer map wrong");
  a_uart_map: assert property (@(posedge clk) disable iff (!rst_b)
    {async_serial_c_clock_gate, async_serial_b_clock_gate, async_serial_a_clock_gate}
      == unit_clock_en[2:0])
    else $error("serial map wrong");
  a_reset_zero: assert property (@(posedge clk)
    !rst_b |=> (sleep_clock_gate_reg_q == 32'h00000000 && en_q == 32'h00000000))
    else $error("reset value wrong");

  sequence s_gated_access;
    unit_access && ((unit_select & unit_clock_en) == 32'h00000000);
  endsequence
  sequence s_sleep_read;
    addr_phase && !hwrite && (a_off == sleep_gate_pkg::sleep_gate_off);
  endsequence
  sequence s_source_change;
    en_d != en_q;
  endsequence
  sequence s_source_steady;
    en_d == en_q;
  endsequence
  sequence s_run_write;
    wr_pend_q && (wr_addr_q == sleep_gate_pkg::run_gate_off);
  endsequence

  a_fault_status: assert property (@(posedge clk) disable iff (!rst_b)
    s_gated_access |=> irq_status_q[sleep_gate_pkg::irq_fault_bit])
    else $error("fault event not recorded");
  a_fault_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    !unit_access |=> !unit_fault)
    else $error("fault without access");
  a_status_sticky: assert property (@(posedge clk) disable iff (!rst_b)
    (irq_status_q[sleep_gate_pkg::irq_fault_bit] && !wr_stat)
      |=> irq_status_q[sleep_gate_pkg::irq_fault_bit])
    else $error("fault status lost");

  a_switch_event: assert property (@(posedge clk) disable iff (!rst_b)
    s_source_change |=> irq_status_q[sleep_gate_pkg::irq_switch_bit])
    else $error("switch event not recorded");
  a_switch_clear: assert property (@(posedge clk) disable iff (!rst_b)
    (wr_stat && hwdata[sleep_gate_pkg::irq_switch_bit] && !switching)
      |=> !irq_status_q[sleep_gate_pkg::irq_switch_bit])
    else $error("switch status not cleared");
  a_irq_masked: assert property (@(posedge clk) disable iff (!rst_b)
    (irq_mask_q == 32'h00000000) |-> !irq)
    else $error("irq while masked");

  a_en_steady: assert property (@(posedge clk) disable iff (!rst_b)
    s_source_steady |=> $stable(unit_clock_en))
    else $error("enables moved without cause");
  a_en_follow: assert property (@(posedge clk) disable iff (!rst_b)
    s_source_change |=> (unit_clock_en == $past(en_d)))
    else $error("enables missed source change");
  a_auto_off_run: assert property (@(posedge clk) disable iff (!rst_b)
    (sleeping && !auto_clock_gating) |=> (en_q == $past(run_clock_gate_reg_q)))
    else $error("sleep values used without auto gating");

  a_sleep_readback: assert property (@(posedge clk) disable iff (!rst_b)
    s_sleep_read |=> (hrdata == $past(sleep_clock_gate_reg_d)))
    else $error("gate register read wrong");
  a_hrdata_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !(addr_phase && !hwrite) |=> $stable(hrdata))
    else $error("read data moved");
  a_run_write: assert property (@(posedge clk) disable iff (!rst_b)
    s_run_write |=> (run_clock_gate_reg_q == fld($past(hwdata), sleep_gate_pkg::gate_mask)))
    else $error("run gate write lost");

  a_ctrl_write: assert property (@(posedge clk) disable iff (!rst_b)
    wr_ctrl |=> (auto_clock_gating == $past(hwdata[sleep_gate_pkg::auto_gating_bit])))
    else $error("auto gating write lost");
  a_mask_write: assert property (@(posedge clk) disable iff (!rst_b)
    wr_mask |=> (irq_mask_q == fld($past(hwdata), sleep_gate_pkg::irq_mask_bits)))
    else $error("mask write lost");
  a_ctrl_reserved: assert property (@(posedge clk) disable iff (!rst_b)
    (run_clock_config_reg_q & ~sleep_gate_pkg::ctrl_mask) == 32'h00000000)
    else $error("control reserved bit set");

  a_run_reserved: assert property (@(posedge clk) disable iff (!rst_b)
    (run_clock_gate_reg_q & ~sleep_gate_pkg::gate_mask) == 32'h00000000)
    else $error("run reserved bit set");
  a_en_reserved: assert property (@(posedge clk) disable iff (!rst_b)
    (unit_clock_en & ~sleep_gate_pkg::gate_mask) == 32'h00000000)
    else $error("reserved enable set");
  a_timer_mid_map: assert property (@(posedge clk) disable iff (!rst_b)
    {gp_timer_c_clock_gate, gp_timer_b_clock_gate} == unit_clock_en[18:17])
    else $error("middle timer map wrong");

  a_twowire_map: assert property (@(posedge clk) disable iff (!rst_b)
    twowire_clock_gate == unit_clock_en[12])
    else $error("two-wire map wrong");
  a_quad_map: assert property (@(posedge clk) disable iff (!rst_b)
    quad_encoder_clock_gate == unit_clock_en[8])
    else $error("encoder map wrong");
  a_sync_map: assert property (@(posedge clk) disable iff (!rst_b)
    sync_serial_clock_gate == unit_clock_en[4])
    else $error("sync serial map wrong");

  a_reset_clear: assert property (@(posedge clk)
    !rst_b |=> (hrdata == 32'h00000000 && !unit_fault && irq_status_q == 32'h00000000
      && run_clock_gate_reg_q == 32'h00000000))
    else $error("reset state wrong");
endmodule

// ### logic/sleep_gate_pkg.sv
// What this block does
// - each implemented sleep gate bit is one unit's clock enable
// - access to a unit with clear enable gets an error response
// - gate register resets to all zero, every unit unclocked
// - gate register sits at byte offset 0x114, 32 bits, read/write fields
// - sleep enables come from this register; the run register is separate
// - sleep values apply only when auto clock gating is set
// - bit 24 gates comparator 0
// - bits 19..16 gate timers 3..0
// - bit 12 gates two-wire unit 0
// - bit 8 gates quadrature encoder unit 0
// - bit 4 gates synchronous serial unit 0
// - bits 2..0 gate asynchronous serial units 2..0
// - reserved bits read zero and ignore writes
package sleep_gate_pkg;
  localparam logic [11:0] sleep_gate_off = 12'h114;
  localparam logic [11:0] run_gate_off = 12'h104;
  localparam logic [11:0] ctrl_off = 12'h060;
  localparam logic [11:0] irq_status_off = 12'h200;
  localparam logic [11:0] irq_mask_off = 12'h204;
  localparam logic [31:0] gate_reset = 32'h00000000;
  localparam logic [31:0] gate_mask = 32'h010F1117;
  localparam int comparator_bit = 24;
  localparam int gp_timer_d_bit = 19;
  localparam int gp_timer_a_bit = 16;
  localparam int twowire_bit = 12;
  localparam int quad_encoder_bit = 8;
  localparam int sync_serial_bit = 4;
  localparam int async_serial_c_bit = 2;
  localparam int async_serial_a_bit = 0;
  localparam int auto_gating_bit = 27;
  localparam logic [31:0] ctrl_mask = 32'h08000000;
  localparam logic [1:0] irq_fault_bit = 2'h0;
  localparam logic [1:0] irq_switch_bit = 2'h1;
  localparam logic [31:0] irq_mask_bits = 32'h00000003;
endpackage

// ### verification/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, hsel, hwrite, hready, sleeping, unit_access;
  logic [31:0] haddr, hwdata, unit_select, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, unit_fault, irq;
  logic [31:0] hrdata, unit_clock_en;
  logic g_cmp, g_ta, g_tb, g_tc, g_td, g_tw, g_qe, g_ss, g_ua, g_ub, g_uc;
  int bad_count, comparisons;
  logic [31:0] pat [2] = '{32'h010A1015, 32'h00051102};
  assign hready = hreadyout;
  sleep_clock_gating dut_u (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sleeping(sleeping),
    .unit_access(unit_access), .unit_select(unit_select), .unit_fault(unit_fault),
    .unit_clock_en(unit_clock_en), .comparator_clock_gate(g_cmp),
    .gp_timer_a_clock_gate(g_ta), .gp_timer_b_clock_gate(g_tb), .gp_timer_c_clock_gate(g_tc),
    .gp_timer_d_clock_gate(g_td), .twowire_clock_gate(g_tw), .quad_encoder_clock_gate(g_qe),
    .sync_serial_clock_gate(g_ss), .async_serial_a_clock_gate(g_ua),
    .async_serial_b_clock_gate(g_ub), .async_serial_c_clock_gate(g_uc), .irq(irq));
  task finish_test;
    begin
      if (bad_count == 0 && comparisons > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    begin
      comparisons++;
      if (seen !== exp)
      begin
        bad_count++;
        $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // one ahb-lite single word transfer, waits on hready
  task bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
    begin
      hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {20'h00000, a};
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0; hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
      chk("hresp", {31'h0, hresp}, 32'h0);
      chk("hreadyout", {31'h0, hreadyout}, 32'h1);
    end
  endtask
  task settle;
    begin
      repeat (2) @(posedge clk);
      #1;
    end
  endtask
  task t_reset;
    begin
      bus(0, sleep_gate_pkg::sleep_gate_off, 32'h0);
      chk("sleep reset", rd, sleep_gate_pkg::gate_reset);
      chk("enables reset", unit_clock_en, 32'h0);
      chk("irq reset", {31'h0, irq}, 32'h0);
    end
  endtask
  task t_regs;
    begin
      bus(1, sleep_gate_pkg::sleep_gate_off, 32'hFFFFFFFF);
      bus(0, sleep_gate_pkg::sleep_gate_off, 32'h0);
      chk("sleep rw", rd, 32'h010F1117);
      bus(0, 12'h3F0, 32'h0);
      chk("unmapped", rd, 32'h0);
    end
  endtask
  task t_source;
    begin
      bus(1, sleep_gate_pkg::run_gate_off, 32'h00000011);
      sleeping <= 1'b0;
      settle;
      chk("run en", unit_clock_en, 32'h00000011);
      sleeping <= 1'b1;
      settle;
      chk("no auto", unit_clock_en, 32'h00000011);
      bus(1, sleep_gate_pkg::ctrl_off, 32'h08000000);
      foreach (pat[i])
      begin
        bus(1, sleep_gate_pkg::sleep_gate_off, pat[i]);
        settle;
        chk("sleep en", unit_clock_en, pat[i]);
        chk("named", {7'h0, g_cmp, 4'h0, g_td, g_tc, g_tb, g_ta, 3'h0, g_tw, 3'h0, g_qe,
          3'h0, g_ss, 1'b0, g_uc, g_ub, g_ua}, pat[i]);
      end
      sleeping <= 1'b0;
      settle;
      chk("wake en", unit_clock_en, 32'h00000011);
    end
  endtask
  task t_rereset;
    begin
      bus(1, sleep_gate_pkg::sleep_gate_off, 32'h00000011);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      bus(0, sleep_gate_pkg::sleep_gate_off, 32'h0);
      chk("sleep rereset", rd, sleep_gate_pkg::gate_reset);
      chk("enables rereset", unit_clock_en, 32'h0);
    end
  endtask
  task access(input logic [31:0] sel, input logic exp);
    begin
      @(posedge clk);
      unit_access <= 1'b1;
      unit_select <= sel;
      @(posedge clk);
      unit_access <= 1'b0;
      #1;
      chk("fault", {31'h0, unit_fault}, {31'h0, exp});
    end
  endtask
  task t_fault_irq;
    begin
      bus(1, sleep_gate_pkg::irq_mask_off, 32'h0);
      bus(1, sleep_gate_pkg::irq_status_off, 32'h00000003);
      access(32'h00000001, 1'b0);
      access(32'h00000100, 1'b1);
      bus(0, sleep_gate_pkg::irq_status_off, 32'h0);
      chk("status", rd, 32'h00000001);
      chk("irq masked", {31'h0, irq}, 32'h0);
      bus(1, sleep_gate_pkg::irq_mask_off, 32'h00000001);
      #1;
      chk("irq set", {31'h0, irq}, 32'h1);
      bus(1, sleep_gate_pkg::irq_status_off, 32'h00000001);
      #1;
      chk("irq clear", {31'h0, irq}, 32'h0);
    end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    #50000;
    bad_count++;
    finish_test;
  end
  initial
  begin
    rst_b = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; sleeping = 1'b0; unit_access = 1'b0; unit_select = 32'h0;
    bad_count = 0; comparisons = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset;
    t_regs;
    t_source;
    t_fault_irq;
    t_rereset;
    finish_test;
  end
endmodule
